// [secp_array.sv]
// Byte-wide storage array, written in the core domain
module secp_array #(
    parameter int BYTES = 512,
    parameter int IW = 9
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [IW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [IW-1:0] raddr0,
    input wire logic [IW-1:0] raddr1,
    output logic [7:0] rdata0,
    output logic [7:0] rdata1
);
    logic [7:0] mem [BYTES];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read ports are asynchronous; reads are served even while a write runs
    assign rdata0 = mem[raddr0];
    assign rdata1 = mem[raddr1];
endmodule // secp_array

// [secp_core.sv]
// Serial EEPROM command port: link decoder, sequencer and output driver
//
// How it works
// - Strap high or open gives 16-bit words, strap low gives 8-bit words.
// - Array holds 2048 or 4096 bits, split into 8- or 16-bit words.
// - Frame opens on select high; start bit one, opcode, address, in order.
// - Read is opcode 10 with nine or eight address bits.
// - A zero dummy bit precedes the first read word.
// - Output data changes only on rising shift clock edges.
// - Held select streams following words back to back, no dummy.
// - Enable is opcode 00, address top bits 11; needed before programming.
// - Programming is disabled from power-up.
// - Enable lasts until a disable instruction or power loss.
// - Programming instructions are ignored while disabled.
// - Erase, opcode 11, sets the word to ones; starts at decode.
// - Write, opcode 01, address then data; no erase needed first.
// - Erase-all, opcode 00 top bits 10, sets whole array to ones.
// - Fill-all, opcode 00 top bits 01, writes data word everywhere.
// - Disable, opcode 00 top bits 00, blocks later programming.
// - Host holds select low 250 ns; on raise, status appears.
// - Status output reads one once programming has finished.
// - Each programming cycle ends within 10 ms.
// - Status output reads zero while programming runs.
// - Write programming starts only after the last data bit.
// - No status if select rises after the cycle ended.
// - Read works whether programming is enabled or not.
module secp_core #(
    parameter int ARRAY_BITS = secp_pkg::ARRAY_BITS_LARGE,
    parameter int PROG_CYCLES = secp_pkg::PROG_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic shift_clock_in,
    input wire logic chip_select,
    input wire logic serial_in,
    input wire logic word_width_strap,
    output logic serial_out,
    output logic serial_out_en,
    output logic prog_busy,
    output logic prog_enabled
);
    localparam int BYTES = ARRAY_BITS / 8;
    localparam int IW = $clog2(BYTES);
    localparam int TW = $clog2(PROG_CYCLES);
    localparam logic [TW-1:0] TIMER_LAST = TW'(PROG_CYCLES - 1);
    localparam logic [IW-1:0] BYTE_LAST = IW'(BYTES - 1);

    // The fill walk must end inside the timed cycle
    if (ARRAY_BITS != secp_pkg::ARRAY_BITS_SMALL && ARRAY_BITS != secp_pkg::ARRAY_BITS_LARGE) begin : g_chk_bits
        $error("ARRAY_BITS must be 2048 or 4096");
    end
    if (PROG_CYCLES <= BYTES) begin : g_chk_time
        $error("PROG_CYCLES must exceed the array byte count");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossings

    logic frame_clr;
    logic strap_sk, busy_sk;
    logic cs_s, req_s, rd_bit_s, rd_en_s;
    logic busy_r, req_tgl_r, rd_bit_r, rd_en_r;

    // Select low ends the frame even with the shift clock stopped
    assign frame_clr = rst | ~chip_select;

    secp_sync #(.W(2), .RST_VAL({secp_pkg::STRAP_RST, 1'b0})) u_sync_sk (
        .clk(shift_clock_in),
        .rst(rst),
        .d({word_width_strap, busy_r}),
        .q({strap_sk, busy_sk})
    );

    secp_sync #(.W(4)) u_sync_ref (
        .clk(ref_clk),
        .rst(rst),
        .d({chip_select, req_tgl_r, rd_bit_r, rd_en_r}),
        .q({cs_s, req_s, rd_bit_s, rd_en_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: instruction decoder

    secp_pkg::secp_phase_t phase_r;
    logic [4:0] cnt_r;
    logic [1:0] op_r;
    logic [8:0] addr_r, addr_nxt;
    logic [15:0] data_r, data_nxt, rd_sr_r, rd_word;
    logic [4:0] alen_last, dlen_last;
    logic [1:0] ext_sel, ext_sel_r;
    logic last_addr, last_data;
    logic prog_en_r;
    logic [IW-1:0] raddr0, raddr1;
    logic [8:0] rd_addr;
    logic [7:0] rdata0, rdata1;

    assign alen_last = strap_sk ? 5'(secp_pkg::ADDR_LEN_X16 - 1) : 5'(secp_pkg::ADDR_LEN_X8 - 1);
    assign dlen_last = strap_sk ? 5'(secp_pkg::DATA_LEN_X16 - 1) : 5'(secp_pkg::DATA_LEN_X8 - 1);
    assign addr_nxt = {addr_r[7:0], serial_in};
    assign data_nxt = {data_r[14:0], serial_in};
    assign last_addr = (phase_r == secp_pkg::PH_ADDR) && (cnt_r == alen_last);
    assign last_data = (phase_r == secp_pkg::PH_DATA) && (cnt_r == dlen_last);
    assign ext_sel = strap_sk ? addr_nxt[7:6] : addr_nxt[8:7];
    assign ext_sel_r = strap_sk ? addr_r[7:6] : addr_r[8:7];

    // Word read address: the decoded one, or the next one while streaming
    assign rd_addr = (phase_r == secp_pkg::PH_READ) ? addr_r + 9'h001 : addr_nxt;
    assign raddr0 = strap_sk ? IW'({rd_addr[7:0], 1'b0}) : IW'(rd_addr);
    assign raddr1 = raddr0 | IW'(1);
    // Byte words sit left-aligned so bit 15 always leaves first
    assign rd_word = strap_sk ? {rdata0, rdata1} : {rdata0, 8'h00};

    always_ff @(posedge shift_clock_in or posedge frame_clr) begin
        if (frame_clr) begin
            phase_r <= secp_pkg::PH_START;
            cnt_r <= '0;
            op_r <= '0;
            addr_r <= '0;
            data_r <= '0;
            rd_sr_r <= '0;
            rd_bit_r <= 1'b0;
            rd_en_r <= 1'b0;
        end else begin
            case (phase_r)
                secp_pkg::PH_START: begin
                    if (busy_sk) begin
                        phase_r <= secp_pkg::PH_IDLE;
                    end else if (serial_in == secp_pkg::START_MARK) begin
                        phase_r <= secp_pkg::PH_OP;
                    end
                end
                secp_pkg::PH_OP: begin
                    op_r <= {op_r[0], serial_in};
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == 5'(secp_pkg::OP_LEN - 1)) begin
                        phase_r <= secp_pkg::PH_ADDR;
                        cnt_r <= '0;
                    end
                end
                secp_pkg::PH_ADDR: begin
                    addr_r <= addr_nxt;
                    cnt_r <= cnt_r + 5'h01;
                    if (last_addr) begin
                        cnt_r <= '0;
                        if (op_r == secp_pkg::OP_READ) begin
                            phase_r <= secp_pkg::PH_READ;
                            rd_bit_r <= secp_pkg::DUMMY_BIT;
                            rd_en_r <= 1'b1;
                            rd_sr_r <= rd_word;
                        end else if (op_r == secp_pkg::OP_WRITE ||
                                     (op_r == secp_pkg::OP_EXT && ext_sel == secp_pkg::EXT_FILL_ALL)) begin
                            phase_r <= secp_pkg::PH_DATA;
                        end else begin
                            phase_r <= secp_pkg::PH_IDLE;
                        end
                    end
                end
                secp_pkg::PH_DATA: begin
                    data_r <= data_nxt;
                    cnt_r <= cnt_r + 5'h01;
                    if (last_data) begin
                        phase_r <= secp_pkg::PH_IDLE;
                    end
                end
                secp_pkg::PH_READ: begin
                    // Bits leave on rising edges only
                    rd_bit_r <= rd_sr_r[15];
                    rd_sr_r <= {rd_sr_r[14:0], 1'b0};
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == dlen_last) begin
                        cnt_r <= '0;
                        addr_r <= addr_r + 9'h001;
                        rd_sr_r <= rd_word;
                    end
                end
                default: begin
                    phase_r <= secp_pkg::PH_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: enable state and command hand-off

    logic iss_en, iss_dis, iss_erase, iss_erall, iss_write, iss_fill;
    secp_pkg::secp_kind_t cmd_kind_r;
    logic [8:0] cmd_addr_r;
    logic [15:0] cmd_data_r;
    logic cmd_org_r;

    assign iss_en = last_addr && op_r == secp_pkg::OP_EXT && ext_sel == secp_pkg::EXT_ENABLE;
    assign iss_dis = last_addr && op_r == secp_pkg::OP_EXT && ext_sel == secp_pkg::EXT_DISABLE;
    assign iss_erase = last_addr && op_r == secp_pkg::OP_ERASE && prog_en_r;
    assign iss_erall = last_addr && op_r == secp_pkg::OP_EXT && ext_sel == secp_pkg::EXT_ERASE_ALL
                       && prog_en_r;
    assign iss_write = last_data && op_r == secp_pkg::OP_WRITE && prog_en_r;
    assign iss_fill = last_data && op_r == secp_pkg::OP_EXT && ext_sel_r == secp_pkg::EXT_FILL_ALL
                      && prog_en_r;

    // Survives deselect; only power-up reset or a disable instruction clears it
    always_ff @(posedge shift_clock_in or posedge rst) begin
        if (rst) begin
            prog_en_r <= 1'b0;
        end else if (iss_en) begin
            prog_en_r <= 1'b1;
        end else if (iss_dis) begin
            prog_en_r <= 1'b0;
        end
    end

    // Fields stay stable after the toggle, so the core may sample them late
    always_ff @(posedge shift_clock_in or posedge rst) begin
        if (rst) begin
            req_tgl_r <= 1'b0;
            cmd_kind_r <= secp_pkg::K_WRITE;
            cmd_addr_r <= '0;
            cmd_data_r <= '0;
            cmd_org_r <= secp_pkg::STRAP_RST;
        end else if (iss_erase || iss_erall || iss_write || iss_fill) begin
            req_tgl_r <= ~req_tgl_r;
            cmd_addr_r <= iss_erase ? addr_nxt : addr_r;
            cmd_data_r <= data_nxt;
            cmd_org_r <= strap_sk;
            if (iss_erase) begin
                cmd_kind_r <= secp_pkg::K_ERASE;
            end else if (iss_erall) begin
                cmd_kind_r <= secp_pkg::K_ERASE_ALL;
            end else if (iss_write) begin
                cmd_kind_r <= secp_pkg::K_WRITE;
            end else begin
                cmd_kind_r <= secp_pkg::K_FILL_ALL;
            end
        end
    end

    assign prog_enabled = prog_en_r;

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: self-timed programming sequencer

    secp_pkg::secp_core_t st_r;
    logic req_seen_r, start, walk_on_r, all_kind, we;
    logic [TW-1:0] timer_r;
    logic [IW-1:0] walk_r, walk_first, walk_last, base;
    logic [7:0] wdata;

    assign start = (req_s != req_seen_r) && (st_r == secp_pkg::C_IDLE);
    assign all_kind = cmd_kind_r == secp_pkg::K_ERASE_ALL || cmd_kind_r == secp_pkg::K_FILL_ALL;
    assign base = cmd_org_r ? IW'({cmd_addr_r[7:0], 1'b0}) : IW'(cmd_addr_r);
    assign walk_first = all_kind ? '0 : base;
    assign walk_last = all_kind ? BYTE_LAST : (cmd_org_r ? (base | IW'(1)) : base);
    assign we = (st_r == secp_pkg::C_PROG) && walk_on_r;
    // Plain overwrite, no erase pass needed
    assign wdata = (cmd_kind_r == secp_pkg::K_ERASE || cmd_kind_r == secp_pkg::K_ERASE_ALL)
                   ? secp_pkg::ERASED_BYTE
                   : ((cmd_org_r && !walk_r[0]) ? cmd_data_r[15:8] : cmd_data_r[7:0]);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= secp_pkg::C_IDLE;
            busy_r <= 1'b0;
            timer_r <= '0;
            walk_r <= '0;
            walk_on_r <= 1'b0;
            req_seen_r <= 1'b0;
        end else begin
            req_seen_r <= req_s;
            case (st_r)
                secp_pkg::C_IDLE: begin
                    if (start) begin
                        st_r <= secp_pkg::C_PROG;
                        busy_r <= 1'b1;
                        timer_r <= '0;
                        walk_r <= walk_first;
                        walk_on_r <= 1'b1;
                    end
                end
                default: begin
                    timer_r <= timer_r + TW'(1);
                    if (walk_on_r) begin
                        walk_r <= walk_r + IW'(1);
                        walk_on_r <= walk_r != walk_last;
                    end
                    if (timer_r == TIMER_LAST) begin
                        st_r <= secp_pkg::C_IDLE;
                        busy_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    secp_array #(.BYTES(BYTES), .IW(IW)) u_array (
        .clk(ref_clk),
        .we(we),
        .waddr(walk_r),
        .wdata(wdata),
        .raddr0(raddr0),
        .raddr1(raddr1),
        .rdata0(rdata0),
        .rdata1(rdata1)
    );

    assign prog_busy = busy_r;

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: status and data output

    logic cs_prev_r, cs_rise, arm_r, status_r, dout_r, dout_en_r;

    assign cs_rise = cs_s && !cs_prev_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cs_prev_r <= 1'b0;
            arm_r <= 1'b0;
        end else begin
            cs_prev_r <= cs_s;
            if (start) begin
                arm_r <= 1'b1;
            end else if (!busy_r) begin
                // Every select rise during the cycle shows status, not only the first
                arm_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_r <= 1'b0;
        end else if (!cs_s) begin
            status_r <= 1'b0;
        end else if (cs_rise && arm_r && busy_r) begin
            status_r <= 1'b1;
        end
    end

    // Read bits follow the link edge after the two-flop synchroniser and the output register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dout_r <= 1'b0;
            dout_en_r <= 1'b0;
        end else begin
            dout_r <= status_r ? !busy_r : rd_bit_s;
            dout_en_r <= cs_s && (status_r || rd_en_s);
        end
    end

    assign serial_out = dout_r;
    assign serial_out_en = dout_en_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence read_issue_s;
        last_addr && op_r == secp_pkg::OP_READ;
    endsequence
    sequence dummy_then_stream_s;
        (rd_en_r && rd_bit_r == secp_pkg::DUMMY_BIT && phase_r == secp_pkg::PH_READ) ##1 rd_en_r;
    endsequence

    dummy_first_a: assert property (@(posedge shift_clock_in) disable iff (frame_clr)
        read_issue_s |=> dummy_then_stream_s) else $error("read did not open with dummy bit");
    locked_write_a: assert property (@(posedge shift_clock_in) disable iff (rst)
        (last_data && !prog_en_r) |=> req_tgl_r == $past(req_tgl_r)) else $error("write accepted while locked");
    enable_set_a: assert property (@(posedge shift_clock_in) disable iff (rst)
        iss_en |=> prog_en_r) else $error("enable instruction had no effect");
    disable_set_a: assert property (@(posedge shift_clock_in) disable iff (rst)
        iss_dis |=> !prog_en_r) else $error("disable instruction had no effect");
    busy_ignore_a: assert property (@(posedge shift_clock_in) disable iff (frame_clr)
        (phase_r == secp_pkg::PH_START && busy_sk) |=> phase_r == secp_pkg::PH_IDLE)
        else $error("instruction accepted while busy");
    prog_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        start |=> busy_r && timer_r == '0 && we) else $error("programming did not start");
    prog_time_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(busy_r) |-> $past(timer_r) == TIMER_LAST) else $error("programming time wrong");
    status_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
        (status_r && busy_r && cs_s) |=> dout_en_r && !dout_r) else $error("busy not shown as zero");
    status_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
        (status_r && !busy_r && cs_s) |=> dout_en_r && dout_r) else $error("ready not shown as one");
    late_select_a: assert property (@(posedge ref_clk) disable iff (rst)
        (cs_rise && !busy_r) |=> !status_r) else $error("status shown after cycle end");
    release_out_a: assert property (@(posedge ref_clk) disable iff (rst)
        !cs_s |=> !dout_en_r) else $error("output driven while deselected");

endmodule // secp_core

// [secp_host_model.sv]
// Host side model of the serial link: select, shift clock, data in, resolved data out
module secp_host_model (
    input wire logic ref_clk,
    output logic shift_clock_in,
    output logic chip_select,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_en,
    output wire logic so_line
);
    timeunit 1ns;
    timeprecision 1ns;

    // Released output floats; no pull on this line
    assign so_line = serial_out_en ? serial_out : 1'bz;

    initial begin
        shift_clock_in = 1'b0;
        chip_select = 1'b0;
        serial_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift clock idles low between bits; 500 ns high and low keeps it at 1 MHz
    task automatic sk_bit(input logic di, output logic dq);
        serial_in = di;
        repeat (5) @(negedge ref_clk);
        shift_clock_in = 1'b1;
        repeat (5) @(negedge ref_clk);
        shift_clock_in = 1'b0;
        dq = so_line;
    endtask

    task automatic put(input logic [31:0] v, input int n, output logic dq);
        for (int i = n - 1; i >= 0; i--) begin
            sk_bit(v[i], dq);
        end
    endtask

    task automatic cmd(input logic [1:0] op, input logic [8:0] a, input int al, input logic [15:0] d, input int dl,
                       output logic [15:0] q);
        logic b;
        chip_select = 1'b1;
        repeat (2) @(negedge ref_clk);
        put({29'h0, secp_pkg::START_MARK, op}, 3, b);
        put({23'h0, a}, al, b);
        // An empty data field would hand back an unknown sample
        if (dl > 0) begin
            put({16'h0, d}, dl, b);
        end
        q = {15'h0, b};
    endtask

    task automatic get(input int n, output logic [15:0] q);
        logic b;
        q = '0;
        for (int i = 0; i < n; i++) begin
            sk_bit(1'b0, b);
            q = {q[14:0], b};
        end
    endtask

    // Raise select and let the status reach the pin
    task automatic sel();
        chip_select = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask

    // 400 ns low, above the 250 ns minimum
    task automatic drop();
        chip_select = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask

    // Idle edges let the decoder see strap and busy changes
    task automatic gap();
        logic b;
        sk_bit(1'b0, b);
        sk_bit(1'b0, b);
    endtask
endmodule // secp_host_model

// [secp_pkg.sv]
// Shared constants and types of the serial EEPROM command port
package secp_pkg;

    // Core clock rate and self-timed programming time
    localparam int REF_CLK_KHZ = 10000;
    localparam int PROG_TIME_MS = 10;
    // Longest time, so rounded down; the product is exact here
    localparam int PROG_CYCLES_DEF = PROG_TIME_MS * REF_CLK_KHZ;

    // Array size in bits by variant
    localparam int ARRAY_BITS_SMALL = 2048;
    localparam int ARRAY_BITS_LARGE = 4096;

    // Field lengths on the link
    localparam int OP_LEN = 2;
    localparam int ADDR_LEN_X8 = 9;
    localparam int ADDR_LEN_X16 = 8;
    localparam int DATA_LEN_X8 = 8;
    localparam int DATA_LEN_X16 = 16;

    // Opcodes and the leading address bits of the extended group
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_FILL_ALL = 2'h1;
    localparam logic [1:0] EXT_DISABLE = 2'h0;

    localparam logic START_MARK = 1'b1;
    localparam logic DUMMY_BIT = 1'b0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // Strap reset value: open strap means 16-bit words
    localparam logic STRAP_RST = 1'b1;

    typedef enum logic [2:0] {PH_START, PH_OP, PH_ADDR, PH_DATA, PH_READ, PH_IDLE} secp_phase_t;
    typedef enum logic [1:0] {K_WRITE, K_ERASE, K_ERASE_ALL, K_FILL_ALL} secp_kind_t;
    typedef enum logic {C_IDLE, C_PROG} secp_core_t;

endpackage

// [secp_sync.sv]
// Two-flop level synchroniser, one stage pair per bit
module secp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // secp_sync

// [tb_serial_eeprom_command_port.sv]
// Self-checking bench of the serial EEPROM command port
module tb_serial_eeprom_command_port;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PROG = 600;
    logic ref_clk, rst, word_width_strap, shift_clock_in, chip_select, serial_in;
    logic serial_out, serial_out_en, prog_busy, prog_enabled;
    wire logic so_line;
    int error_cnt = 0;
    int check_count = 0;
    logic [15:0] q;

    secp_core #(.ARRAY_BITS(secp_pkg::ARRAY_BITS_LARGE), .PROG_CYCLES(PROG)) secp_core_i (.ref_clk(ref_clk),
        .rst(rst), .shift_clock_in(shift_clock_in), .chip_select(chip_select), .serial_in(serial_in),
        .word_width_strap(word_width_strap), .serial_out(serial_out), .serial_out_en(serial_out_en),
        .prog_busy(prog_busy), .prog_enabled(prog_enabled));
    secp_host_model secp_host_model_i (.ref_clk(ref_clk), .shift_clock_in(shift_clock_in),
        .chip_select(chip_select), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .so_line(so_line));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic int alen();
        return word_width_strap ? secp_pkg::ADDR_LEN_X16 : secp_pkg::ADDR_LEN_X8;
    endfunction

    function automatic logic [8:0] ext(input logic [1:0] c);
        return word_width_strap ? {1'b0, c, 6'h0} : {c, 7'h0};
    endfunction

    // Status is only valid if select rises while the cycle still runs
    task automatic status_wait();
        int n = 0;
        secp_host_model_i.sel();
        chk(so_line, 1'b0);
        while (so_line !== 1'b1 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        chk(so_line, 1'b1);
        chk(16'(n < PROG), 16'h1);
        chk(prog_busy, 1'b0);
        secp_host_model_i.drop();
        secp_host_model_i.gap();
    endtask

    task automatic prog(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d, input int dl);
        secp_host_model_i.cmd(op, a, alen(), d, dl, q);
        secp_host_model_i.drop();
        status_wait();
    endtask

    task automatic refused(input logic [1:0] op, input logic [8:0] a);
        secp_host_model_i.cmd(op, a, alen(), 16'h0011, word_width_strap ? 16 : 8, q);
        secp_host_model_i.drop();
        repeat (20) @(negedge ref_clk);
        chk(prog_busy, 1'b0);
        secp_host_model_i.gap();
    endtask

    task automatic rd(input logic [8:0] a, input logic [15:0] e0, input logic [15:0] e1);
        int w = word_width_strap ? 16 : 8;
        secp_host_model_i.cmd(secp_pkg::OP_READ, a, alen(), 16'h0, 0, q);
        chk(q, 16'(secp_pkg::DUMMY_BIT));
        secp_host_model_i.get(w, q);
        chk(q, e0);
        secp_host_model_i.get(w, q);
        chk(q, e1);
        secp_host_model_i.drop();
        chk(so_line, 1'bz);
        secp_host_model_i.gap();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        chk(prog_enabled, 1'b0);
        chk(so_line, 1'bz);
        refused(secp_pkg::OP_WRITE, 9'h005);
        $display("t_power_up done");
    endtask

    task automatic t_x16();
        secp_host_model_i.cmd(secp_pkg::OP_EXT, ext(secp_pkg::EXT_ENABLE), alen(), 16'h0, 0, q);
        secp_host_model_i.drop();
        chk(prog_enabled, 1'b1);
        secp_host_model_i.gap();
        prog(secp_pkg::OP_EXT, ext(secp_pkg::EXT_ERASE_ALL), 16'h0, 0);
        rd(9'h0ff, {2{secp_pkg::ERASED_BYTE}}, {2{secp_pkg::ERASED_BYTE}});
        prog(secp_pkg::OP_WRITE, 9'h005, 16'ha5c3, 16);
        prog(secp_pkg::OP_WRITE, 9'h006, 16'h3c5a, 16);
        rd(9'h005, 16'ha5c3, 16'h3c5a);
        prog(secp_pkg::OP_ERASE, 9'h006, 16'h0, 0);
        rd(9'h005, 16'ha5c3, {2{secp_pkg::ERASED_BYTE}});
        $display("t_x16 done");
    endtask

    // A disable sent mid-cycle must be dropped whole
    task automatic t_busy();
        secp_host_model_i.cmd(secp_pkg::OP_WRITE, 9'h010, alen(), 16'h0f0f, 16, q);
        secp_host_model_i.drop();
        // Idle edges carry busy into the link side before the next frame
        secp_host_model_i.gap();
        secp_host_model_i.cmd(secp_pkg::OP_EXT, ext(secp_pkg::EXT_DISABLE), alen(), 16'h0, 0, q);
        secp_host_model_i.drop();
        chk(prog_enabled, 1'b1);
        status_wait();
        secp_host_model_i.cmd(secp_pkg::OP_WRITE, 9'h011, alen(), 16'hf0f0, 16, q);
        secp_host_model_i.drop();
        repeat (PROG + 100) @(negedge ref_clk);
        secp_host_model_i.sel();
        chk(so_line, 1'bz);
        secp_host_model_i.drop();
        secp_host_model_i.gap();
        rd(9'h010, 16'h0f0f, 16'hf0f0);
        $display("t_busy done");
    endtask

    task automatic t_x8();
        word_width_strap = 1'b0;
        secp_host_model_i.gap();
        prog(secp_pkg::OP_EXT, ext(secp_pkg::EXT_FILL_ALL), 16'h005a, 8);
        prog(secp_pkg::OP_WRITE, 9'h1ff, 16'h00c3, 8);
        rd(9'h1ff, 16'h00c3, 16'h005a);
        secp_host_model_i.cmd(secp_pkg::OP_EXT, ext(secp_pkg::EXT_DISABLE), alen(), 16'h0, 0, q);
        secp_host_model_i.drop();
        chk(prog_enabled, 1'b0);
        secp_host_model_i.gap();
        refused(secp_pkg::OP_ERASE, 9'h000);
        rd(9'h000, 16'h005a, 16'h005a);
        $display("t_x8 done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (60000) @(negedge ref_clk);
        error_cnt++;
        $display("Watchdog expired");
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        word_width_strap = 1'b1;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        secp_host_model_i.gap();
        t_power_up();
        t_x16();
        t_busy();
        t_x8();
        end_of_test();
    end
endmodule // tb_serial_eeprom_command_port
